/* File: rtl/module_pins_pkg.sv */
// Shared constants and carrier types for the module control and status pin logic.
// Assumes a single 40 MHz clock; all pin inputs arrive synchronous to it.
package module_pins_pkg;

   // Clock rate and transmit-off deadline
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned TX_OFF_MAX_US   = 10;
   localparam int unsigned TX_OFF_CYCLES   = (TX_OFF_MAX_US * (CLK_HZ / 1_000_000));
   // Cycles the laser driver gets to confirm the laser is dark before a fault
   localparam logic [8:0]  TX_OFF_LIMIT    = 9'(TX_OFF_CYCLES - 1);
   localparam logic [8:0]  TX_CNT_RESET    = 9'h000;

   // Number of internal parts the controller sets up, and per-part init cycles
   localparam int unsigned PART_COUNT      = 3;
   localparam logic [1:0]  PART_LASER      = 2'h0;
   localparam logic [1:0]  PART_LIMAMP     = 2'h1;
   localparam logic [1:0]  PART_RECOVERY   = 2'h2;
   localparam logic [3:0]  INIT_CYCLES     = 4'hF;

   // Controller sequence, Gray coded along reset -> standby -> init -> run
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_INIT    = 2'b01,
      ST_RUN     = 2'b11
   } ctrl_state_t;

   // Status reported by the internal parts
   typedef struct packed {
      logic tx_lock_lost;
      logic laser_fail;
      logic rx_lock_lost;
      logic rx_power_low;
   } part_status_t;

   // Open-drain pin: pull-low drive level, enable
   typedef struct packed {
      logic out;
      logic oe;
   } od_pin_t;

endpackage : module_pins_pkg

/* File: rtl/module_control_status_pins.sv */
// Control and status pin logic of a pluggable optical transceiver module.
// Assumes host-side pull-ups on every open-drain line and synchronous pin inputs.
//
// Notes on behaviour
// - While transmit_off_input is high the transmitter output is switched off.
// - The transmitter is fully off within 10 us of transmit_off_input rising.
// - receive_signal_loss reads high while received power is too low, low otherwise.
// - module_not_ready rises whenever transmit or receive data are invalid.
// - Transmit lock loss, laser failure and receive lock loss each raise module_not_ready.
// - Management traffic is answered only while the deselect input is low.
// - The interrupt line asserts for an important condition whose detail is readable.
// - The presence line is pulled low permanently while the module is fitted.
// - While power-down is high the module stays in low-power standby.
// - A falling edge of power-down resets the whole module, management included.
// - Interrupt, not-ready, signal-loss, presence and management data are open-drain.
// - The controller initialises the three internal parts, then monitors them.
`timescale 1ns/100ps

module module_control_status_pins
   import module_pins_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         transmit_off_input,
   input  wire logic         deselect,
   input  wire logic         power_down,
   input  wire part_status_t part_status,
   input  wire logic         laser_dark,
   input  wire logic         mgmt_data_in,
   input  wire logic         mgmt_status_read,
   input  wire logic         part_init_done,
   output logic              laser_enable,
   output logic              standby,
   output logic              part_init_req,
   output logic [1:0]        part_init_sel,
   output logic              mgmt_enable,
   output logic              mgmt_soft_reset,
   output od_pin_t           receive_signal_loss,
   output od_pin_t           module_not_ready,
   output od_pin_t           interrupt_line,
   output od_pin_t           module_absent,
   output od_pin_t           mgmt_data,
   output part_status_t      latched_cause
);

   ////////////////////////////////////////////////////////////////////////////
   // Power-down edge and internal reset
   logic        power_down_prev;
   logic        soft_reset;
   wire  logic  pd_fall = power_down_prev & ~power_down;

   // A falling edge resets everything below as a power cycle would
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_down_prev <= 1'b1;
         soft_reset      <= 1'b1;
      end else begin
         power_down_prev <= power_down;
         soft_reset      <= pd_fall;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Controller sequence: standby, initialise parts, run
   ctrl_state_t state;
   ctrl_state_t next_state;
   logic [1:0]  part_idx;
   logic [3:0]  init_cnt;
   wire  logic  last_part = (part_idx == 2'(PART_COUNT - 1));
   wire  logic  part_done = part_init_done & (init_cnt == INIT_CYCLES);

   always_comb begin
      next_state = state;
      case (state)
         ST_STANDBY: begin
            if (!power_down) next_state = ST_INIT;
         end
         ST_INIT: begin
            if (power_down) next_state = ST_STANDBY;
            else if (part_done && last_part) next_state = ST_RUN;
         end
         ST_RUN: begin
            if (power_down) next_state = ST_STANDBY;
         end
         default: next_state = ST_STANDBY;
      endcase
   end

   // Each part gets a fixed settle time plus its own done handshake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state    <= ST_STANDBY;
         part_idx <= PART_LASER;
         init_cnt <= 4'h0;
      end else if (soft_reset) begin
         state    <= ST_STANDBY;
         part_idx <= PART_LASER;
         init_cnt <= 4'h0;
      end else begin
         state <= next_state;
         if (state != ST_INIT) begin
            part_idx <= PART_LASER;
            init_cnt <= 4'h0;
         end else if (part_done) begin
            part_idx <= part_idx + 2'h1;
            init_cnt <= 4'h0;
         end else if (init_cnt != INIT_CYCLES) begin
            init_cnt <= init_cnt + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit-off watchdog: laser must report dark within the deadline
   logic [8:0] tx_off_cnt;
   logic       tx_off_fault;
   wire  logic tx_allowed = ~transmit_off_input & (state == ST_RUN);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_off_cnt   <= TX_CNT_RESET;
         tx_off_fault <= 1'b0;
      end else if (soft_reset || tx_allowed || laser_dark) begin
         tx_off_cnt   <= TX_CNT_RESET;
         tx_off_fault <= 1'b0;
      end else if (tx_off_cnt == TX_OFF_LIMIT) begin
         tx_off_fault <= 1'b1;
      end else begin
         tx_off_cnt <= tx_off_cnt + 9'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status decode and interrupt latch
   wire logic data_invalid = part_status.tx_lock_lost | part_status.laser_fail
                           | part_status.rx_lock_lost | tx_off_fault;
   wire logic not_ready    = data_invalid | (state != ST_RUN);
   wire logic mgmt_ok      = ~deselect & (state != ST_STANDBY);
   wire logic new_event    = (state == ST_RUN) & (|part_status);
   logic      irq_pending;

   // Cause bits accumulate; a new event on the read cycle keeps the flag set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_pending   <= 1'b0;
         latched_cause <= '0;
      end else if (soft_reset) begin
         irq_pending   <= 1'b0;
         latched_cause <= '0;
      end else if (new_event) begin
         irq_pending   <= 1'b1;
         latched_cause <= latched_cause | part_status;
      end else if (mgmt_status_read && mgmt_ok) begin
         irq_pending   <= 1'b0;
         latched_cause <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered pin drivers; open-drain outputs only ever pull low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         laser_enable        <= 1'b0;
         standby             <= 1'b1;
         part_init_req       <= 1'b0;
         part_init_sel       <= PART_LASER;
         mgmt_enable         <= 1'b0;
         mgmt_soft_reset     <= 1'b1;
         receive_signal_loss <= '{out: 1'b0, oe: 1'b0};
         module_not_ready    <= '{out: 1'b0, oe: 1'b0};
         interrupt_line      <= '{out: 1'b0, oe: 1'b0};
         module_absent       <= '{out: 1'b0, oe: 1'b1};
         mgmt_data           <= '{out: 1'b0, oe: 1'b0};
      end else begin
         laser_enable        <= tx_allowed;
         standby             <= (state == ST_STANDBY);
         part_init_req       <= (state == ST_INIT) & ~soft_reset;
         part_init_sel       <= part_idx;
         mgmt_enable         <= mgmt_ok & ~soft_reset;
         mgmt_soft_reset     <= soft_reset;
         receive_signal_loss <= '{out: 1'b0, oe: ~part_status.rx_power_low};
         module_not_ready    <= '{out: 1'b0, oe: ~not_ready};
         interrupt_line      <= '{out: 1'b0, oe: irq_pending | new_event};
         module_absent       <= '{out: 1'b0, oe: 1'b1};
         mgmt_data           <= '{out: 1'b0, oe: mgmt_ok & ~mgmt_data_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   chk_laser_off_follow: assert property (@(posedge clk) disable iff (rst)
      transmit_off_input |=> !laser_enable) else $error("laser on while transmit off held");
   chk_dark_deadline: assert property (@(posedge clk) disable iff (rst)
      (transmit_off_input && !laser_dark && !soft_reset && tx_off_cnt == TX_OFF_LIMIT) |=> tx_off_fault)
      else $error("transmit-off deadline not flagged");
   chk_loss_pin: assert property (@(posedge clk) disable iff (rst)
      part_status.rx_power_low |=> !receive_signal_loss.oe) else $error("signal loss not released high");
   chk_fault_not_ready: assert property (@(posedge clk) disable iff (rst)
      (part_status.laser_fail || part_status.rx_lock_lost || part_status.tx_lock_lost)
      |=> !module_not_ready.oe) else $error("fault did not raise not-ready");
   chk_deselect_quiet: assert property (@(posedge clk) disable iff (rst)
      deselect |=> (!mgmt_enable && !mgmt_data.oe)) else $error("traffic answered while deselected");
   // The pin lags the pending flag by one edge, so the hold is judged on the flag
   chk_irq_hold: assert property (@(posedge clk) disable iff (rst)
      (irq_pending && !mgmt_status_read && !soft_reset) |=> (irq_pending && interrupt_line.oe))
      else $error("interrupt dropped before read");
   chk_absent_low: assert property (@(posedge clk) disable iff (rst)
      module_absent.oe && !module_absent.out) else $error("presence not pulled low");
   chk_standby_hold: assert property (@(posedge clk) disable iff (rst)
      power_down [*2] |=> standby) else $error("not in standby while powered down");
   chk_pd_reset: assert property (@(posedge clk) disable iff (rst)
      ($fell(power_down)) |=> ##1 (mgmt_soft_reset && state == ST_STANDBY))
      else $error("power-down release did not reset");
   chk_ready_after_init: assert property (@(posedge clk) disable iff (rst)
      (state != ST_RUN) |=> !module_not_ready.oe) else $error("ready before init done");
   chk_drive_low_only: assert property (@(posedge clk) disable iff (rst)
      !(interrupt_line.out || module_not_ready.out || receive_signal_loss.out || mgmt_data.out))
      else $error("open-drain line driven high");
   chk_tx_fault_bound: assert property (@(posedge clk) disable iff (rst)
      tx_off_cnt <= TX_OFF_LIMIT) else $error("watchdog counter overran");

   cov_init_done:  cover property (@(posedge clk) disable iff (rst) state == ST_INIT ##1 state == ST_RUN);
   cov_irq_read:   cover property (@(posedge clk) disable iff (rst) irq_pending ##1 !irq_pending);
   cov_tx_fault:   cover property (@(posedge clk) disable iff (rst) $rose(tx_off_fault));
   cov_pd_cycle:   cover property (@(posedge clk) disable iff (rst) $fell(power_down));

endmodule : module_control_status_pins

/* File: tb/part_model.sv */
// Behavioural model of the internal parts behind the pin logic.
// Assumes the pin logic's clock and reset; faults and stalls are set by the bench.
`timescale 1ns/100ps

module part_model
   import module_pins_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         laser_enable,
   input  wire logic         part_init_req,
   input  wire logic [1:0]   part_init_sel,
   input  wire part_status_t fault_set,
   input  wire logic         dark_stall,
   output part_status_t      part_status,
   output logic              laser_dark,
   output logic              part_init_done
);
   logic [4:0] init_wait;
   logic [1:0] last_sel;

   // Faults pass straight through as levels
   assign part_status = fault_set;

   ////////////////////////////////////////////////////////////////////////////////
   // Setup is acknowledged late, so the pin logic must wait for it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         init_wait      <= 5'h00;
         last_sel       <= 2'h0;
         part_init_done <= 1'b0;
         laser_dark     <= 1'b0;
      end else begin
         last_sel       <= part_init_sel;
         if (!part_init_req || part_init_sel != last_sel) begin
            init_wait <= 5'h00;
         end else if (init_wait != 5'h14) begin
            init_wait <= init_wait + 5'h01;
         end
         part_init_done <= part_init_req && (init_wait == 5'h14) && (part_init_sel == last_sel);
         laser_dark     <= !laser_enable && !dark_stall;  // Stall is a stuck laser
      end
   end
endmodule : part_model

/* File: tb/module_control_status_pins_tb_top.sv */
// Self-checking bench for the module control and status pin logic.
// Assumes the part model above; the bench plays the host side of the pins.
`timescale 1ns/100ps

`define CHECK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin n_mismatch++; \
   $display("MISMATCH t=%0t act=%0h exp=%0h", $time, act, exp); end end

module module_control_status_pins_tb_top;
   import module_pins_pkg::*;
   logic clk, rst, transmit_off_input, deselect, power_down, mgmt_data_in, mgmt_status_read;
   logic laser_dark, part_init_done, dark_stall, laser_enable, standby, part_init_req;
   logic mgmt_enable, mgmt_soft_reset;
   logic [1:0]   part_init_sel;
   logic [2:0]   seen;
   part_status_t part_status, fault_set, latched_cause;
   od_pin_t      receive_signal_loss, module_not_ready, interrupt_line, module_absent, mgmt_data;
   int           n_mismatch, cmp_count, cycles, i, hits;

   module_control_status_pins module_control_status_pins_inst (.*);
   part_model part_model_inst (.*);

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and a cycle ceiling that cuts a hang short
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Inputs change 1 ns after the edge, outputs are settled by then
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////////////
   // Wait for setup of all parts to end, bounded, then expect a ready module
   // Open-drain: oe low leaves the not-ready line high, so oe stays low during setup
   task automatic init_run();
      cyc(3);
      `CHECK(module_not_ready.oe, 1'b0)
      seen = 3'h0;
      for (i = 0; i < 300 && part_init_req !== 1'b1; i++) cyc(1);
      for (i = 0; i < 300 && part_init_req === 1'b1; i++) begin
         seen[part_init_sel] = 1'b1;
         cyc(1);
      end
      cyc(2);
      `CHECK(seen, 3'h7)
      `CHECK(module_not_ready.oe, 1'b1)
      `CHECK(module_absent.oe, 1'b1)
      `CHECK({module_absent.out, module_not_ready.out, mgmt_data.out}, 3'h0)
      `CHECK(laser_enable, 1'b1)
   endtask : init_run

   // Management answers only while selected; data pulls low, never drives high
   task automatic mgmt_select();
      mgmt_data_in = 1'b0;
      cyc(2);
      `CHECK({mgmt_enable, mgmt_data.oe}, 2'h3)
      deselect = 1'b1;
      cyc(2);
      `CHECK({mgmt_enable, mgmt_data.oe}, 2'h0)
      deselect     = 1'b0;
      mgmt_data_in = 1'b1;
      cyc(2);
      `CHECK({mgmt_enable, mgmt_data.oe}, 2'h2)
   endtask : mgmt_select

   // Each status bit in turn: pin levels, latched cause, interrupt until read
   task automatic fault_walk();
      for (int b = 0; b < 4; b++) begin
         fault_set = part_status_t'(4'h1 << b);
         cyc(2);
         `CHECK(receive_signal_loss.oe, (b != 0))
         `CHECK(module_not_ready.oe, (b == 0))
         `CHECK(interrupt_line.oe, 1'b1)
         `CHECK(latched_cause, part_status_t'(4'h1 << b))
         fault_set = 4'h0;
         cyc(3);
         `CHECK(interrupt_line.oe, 1'b1)
         // A read while deselected must leave the cause and the interrupt alone
         deselect         = 1'b1;
         mgmt_status_read = 1'b1;
         cyc(1);
         mgmt_status_read = 1'b0;
         cyc(1);
         `CHECK({interrupt_line.oe, latched_cause}, 5'h10 | (5'h01 << b))
         deselect         = 1'b0;
         mgmt_status_read = 1'b1;
         cyc(1);
         mgmt_status_read = 1'b0;
         cyc(1);
         `CHECK({interrupt_line.oe, latched_cause}, 5'h00)
         `CHECK({receive_signal_loss.oe, module_not_ready.oe}, 2'h3)
      end
   endtask : fault_walk

   // Transmit off: laser off next edge; a laser that never goes dark is a fault
   task automatic tx_off(input logic stall, input int wait_cyc, input logic exp_nr);
      dark_stall         = stall;
      transmit_off_input = 1'b1;
      cyc(1);
      `CHECK(laser_enable, 1'b0)
      cyc(wait_cyc);
      `CHECK(module_not_ready.oe, !exp_nr)
      transmit_off_input = 1'b0;
      dark_stall         = 1'b0;
      cyc(2);
   endtask : tx_off

   // Standby while power-down is high; its falling edge resets the module
   task automatic power_cycle();
      power_down = 1'b1;
      cyc(3);
      `CHECK({standby, mgmt_enable, laser_enable}, 3'h4)
      power_down = 1'b0;
      hits       = 0;
      for (int k = 0; k < 4; k++) begin
         cyc(1);
         if (mgmt_soft_reset === 1'b1) hits++;
      end
      `CHECK(hits, 1)
      `CHECK(standby, 1'b0)
      init_run();
   endtask : power_cycle

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {transmit_off_input, deselect, power_down, mgmt_data_in, mgmt_status_read, dark_stall} = 6'h00;
      fault_set  = 4'h0;
      rst        = 1'b1;
      n_mismatch = 0;
      cmp_count  = 0;
      cycles     = 0;
      cyc(12);
      `CHECK({standby, module_absent.oe, module_not_ready.oe, laser_enable}, 4'hC)
      rst = 1'b0;
      init_run();
      mgmt_select();
      fault_walk();
      tx_off(1'b0, 420, 1'b0);
      tx_off(1'b1, 395, 1'b0);
      tx_off(1'b1, 410, 1'b1);
      power_cycle();
      finish_test();
   end
endmodule : module_control_status_pins_tb_top
